// [shared/rmhc_pkg.sv]
// constants, register map and state type of the radio module control block
// assumes a 100 MHz mclk; every count of cycles is derived here from a time
`default_nettype none
package rmhc_pkg;
   // clock and time base
   localparam int CLK_HZ = 100_000_000;
   localparam int T_INIT_US = 100;
   localparam int CYC_INIT = CLK_HZ / 1_000_000 * T_INIT_US;
   localparam int T_UNIT_MS = 1;
   localparam int CYC_MS = CLK_HZ / 1000 * T_UNIT_MS;
   localparam int WOR_HZ = 4096;
   localparam int CYC_WOR = CLK_HZ / WOR_HZ;
   localparam int T_CAL_MS = 2;
   localparam int T_CAL_MAX_MS = 1000;
   localparam int T_READY_MS = 5;
   localparam int T_BRK_MS = 1;
   localparam int CYC_BRK = CYC_MS * T_BRK_MS;
   // register offsets (byte addresses)
   localparam logic [7:0] OFS_FLAGS = 8'h00;
   localparam logic [7:0] OFS_PRESC = 8'h04;
   localparam logic [7:0] OFS_COUNT = 8'h08;
   localparam logic [7:0] OFS_WIN = 8'h0C;
   localparam logic [7:0] OFS_CTRL = 8'h10;
   localparam logic [7:0] OFS_STAT = 8'h14;
   // reset values
   localparam logic [15:0] RST_FLAGS = 16'h0000;
   localparam logic [15:0] RST_PRESC = 16'h1000;
   localparam logic [15:0] RST_COUNT = 16'h0001;
   localparam logic [15:0] RST_WIN = 16'h000A;
   localparam logic [7:0] RST_ADDR = 8'h00;
   localparam logic RST_MODE = 1'b0;
   localparam logic [6:0] RST_PINS = 7'h66;
   // flag bit positions and the defined-bit mask
   localparam int F_CFGPIN = 0;
   localparam int F_DREQ = 1;
   localparam int F_BRK = 2;
   localparam int F_PWR = 3;
   localparam int F_CSUM = 5;
   localparam int F_SNIFF = 7;
   localparam int F_CTS = 8;
   localparam int F_LED = 9;
   localparam logic [15:0] FLAGS_MASK = 16'h03AF;
   // synchroniser lanes
   localparam int P_RST = 0;
   localparam int P_CFG = 1;
   localparam int P_DREQ = 2;
   localparam int P_SLP = 3;
   localparam int P_TRX = 4;
   localparam int P_URX = 5;
   localparam int P_CTS = 6;
   // packet buffers
   localparam int BUF_DEPTH = 64;
   localparam logic [7:0] BCAST_ADDR = 8'hFF;
   typedef enum logic [2:0] {
      ST_HOLD, ST_INIT, ST_BOOT, ST_READY, ST_ACTIVE, ST_SLEEP,
      ST_WOR_WAIT, ST_WOR_RX
   } rmhc_state_type;
endpackage
`default_nettype wire

// [verification/rmhc_host_model.sv]
// host side model: uart byte source and sink for the radio control block
// assumes the design's host stream ports and rts, all on mclk
`timescale 1ns/1ns
`default_nettype none
module rmhc_host_model
   import rmhc_pkg::*;
#(
   parameter int MS_P = 20,
   parameter int INIT_P = 10
)(
   input wire logic mclk,
   input wire logic rts_pin_n,
   output logic hin_valid,
   output logic [7:0] hin_data,
   input wire logic hin_ready,
   input wire logic hout_valid,
   input wire logic [7:0] hout_data,
   output logic hout_ready,
   output logic cts_pin_n
);
   logic [7:0] got_q[$];
   // cts kept asserted, otherwise the device would block for good
   assign cts_pin_n = 1'b0;
   initial begin
      hin_valid = 1'b0;
      hin_data = 8'h00;
      hout_ready = 1'b0;
   end
   // sink stalls every other cycle to exercise the output handshake
   always @(posedge mclk) begin
      hout_ready <= ~hout_ready;
      if (hout_valid === 1'b1 && hout_ready) got_q.push_back(hout_data);
   end
   // waits for a settled low rts plus the start margin before sending
   task automatic send(input logic [7:0] b[$]);
      int n;
      n = 0;
      while (n < 5 * MS_P + INIT_P) begin
         @(posedge mclk);
         n = (rts_pin_n === 1'b0) ? n + 1 : 0;
      end
      foreach (b[i]) begin
         hin_valid <= 1'b1;
         hin_data <= b[i];
         do @(posedge mclk); while (hin_ready !== 1'b1);
      end
      hin_valid <= 1'b0;
      hin_data <= ~b[b.size() - 1]; // released line shows no stale byte
   endtask
endmodule
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench of the radio module control block
// assumes the host model beside it and shortened time constants
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import rmhc_pkg::*;
   localparam int MS = 20;
   localparam int INIT = 10;
   localparam int CAL = 2;
   logic mclk, rst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
   logic [7:0] wb_adr_i, hin_data, hout_data, txf_data, rxf_data;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic [3:0] wb_sel_i;
   logic reset_pin_n, config_pin_n, data_req_pin_n, sleep_pin;
   logic transceiver_off_pin, uart_rx_pin, cts_pin_n, rts_pin_n;
   logic rx_led, tx_led, receive_indicate_pin_n, hin_valid, hin_ready;
   logic pkt_end, hout_valid, hout_ready, txf_valid, txf_ready;
   logic radio_tx_start, rxf_valid, rxf_last, cs_ok_in, cs_accept;
   logic op_mode, ready;
   logic [15:0] fl[4] = '{16'h0000, 16'h0001, 16'h00A4, 16'hFFFF};
   logic [7:0] txq[$];
   int bad_count, n_checks, cycles, starts, led_seen;
   rmhc_core #(.CYC_INIT_P(INIT), .CYC_MS_P(MS), .CYC_WOR_P(5),
      .CYC_BRK_P(20), .CAL_MS_P(CAL)) i_dut (.*);
   rmhc_host_model #(.MS_P(MS), .INIT_P(INIT)) i_host (.*);
   always #5 mclk = ~mclk;
   // transceiver fifo stand-in accepting on alternate cycles, plus timeout
   always @(posedge mclk) begin
      txf_ready <= ~txf_ready;
      if (txf_valid === 1'b1 && txf_ready) txq.push_back(txf_data);
      if (radio_tx_start === 1'b1) starts++;
      if (tx_led === 1'b1 || rx_led === 1'b1) led_seen++;
      cycles++;
      if (cycles > 20000) begin
         bad_count++;
         complete_run();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // classic single wishbone cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] r);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      do @(posedge mclk); while (wb_ack_o !== 1'b1);
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge mclk);
      chk("wb ack drop", 0, wb_ack_o);
   endtask
   // flags are only taken up at a reset-pin restart
   task automatic boot(input logic [15:0] f);
      int hi, lo;
      wb(1'b1, 8'h00, {16'h0000, f}, q);
      reset_pin_n <= 1'b0;
      repeat (10 * MS) @(posedge mclk);
      reset_pin_n <= 1'b1;
      hi = 0;
      lo = 0;
      while (rts_pin_n !== 1'b1 && lo < 100) begin
         @(posedge mclk);
         lo++;
      end
      chk("boot rise", 1, lo <= INIT + 10);
      while (rts_pin_n === 1'b1 && hi < 25000) begin
         @(posedge mclk);
         hi++;
      end
      chk("calib", 1, hi >= CAL * MS && hi <= 1000 * MS);
      lo = 0;
      while (ready !== 1'b1 && rts_pin_n === 1'b0 && lo < 1000) begin
         @(posedge mclk);
         lo++;
      end
      chk("ready low", 1, ready === 1'b1 && lo >= 5 * MS);
      chk("ready time", 1, hi + lo <= 1000 * MS);
      wb(1'b0, 8'h14, 32'h0, q);
      chk("flags", f & 16'h03AF, q[31:16]);
   endtask
   task automatic tx_test();
      int n;
      txq.delete();
      starts = 0;
      i_host.send('{8'h11, 8'h22, 8'h33});
      pkt_end <= 1'b1;
      @(posedge mclk);
      pkt_end <= 1'b0;
      n = 0;
      while (rts_pin_n !== 1'b1 && n < 4) begin
         @(posedge mclk);
         n++;
      end
      chk("rts halt", 1, n < 4);
      n = 0;
      while ((txq.size() < 3 || rts_pin_n !== 1'b0) && n < 200) begin
         @(posedge mclk);
         n++;
      end
      chk("tx count", 3, txq.size());
      chk("tx bytes", 24'h112233, {txq[0], txq[1], txq[2]});
      chk("tx start", 1, starts);
   endtask
   task automatic rx_test(input logic [7:0] dest, input logic pass);
      logic [7:0] p[3];
      int n;
      p = '{dest, 8'hA1, 8'hB2};
      i_host.got_q.delete();
      for (n = 0; n < 3; n++) begin
         rxf_valid <= 1'b1;
         rxf_data <= p[n];
         rxf_last <= (n == 2);
         @(posedge mclk);
         chk("rx early", 0, hout_valid);
      end
      rxf_valid <= 1'b0;
      rxf_last <= 1'b0;
      rxf_data <= 8'h4D;
      @(posedge mclk);
      chk("rx ind", !pass, receive_indicate_pin_n);
      n = 0;
      while (!(i_host.got_q.size() > 0 && i_host.got_q[$] == 8'hB2)
            && n < 60) begin
         @(posedge mclk);
         n++;
      end
      chk("rx pass", pass, i_host.got_q.size() != 0);
   endtask
   task automatic wor_test();
      int n;
      wb(1'b1, 8'h04, 32'h2, q);
      wb(1'b1, 8'h08, 32'h3, q);
      wb(1'b1, 8'h0C, 32'h1, q);
      sleep_pin <= 1'b1;
      n = 0;
      while (rts_pin_n !== 1'b1 && n < 50) begin
         @(posedge mclk);
         n++;
      end
      n = 0;
      while (rts_pin_n === 1'b1 && n < 200) begin
         @(posedge mclk);
         n++;
      end
      chk("wake delay", 1, n >= 29 && n <= 36);
      n = 0;
      while (rts_pin_n === 1'b0 && n < 200) begin
         @(posedge mclk);
         n++;
      end
      chk("rx window", 1, n >= MS - 1 && n <= MS + 6);
      n = 0;
      repeat (60) begin
         @(posedge mclk);
         if (rts_pin_n !== 1'b1) n++;
      end
      chk("sleep hold", 0, n);
      sleep_pin <= 1'b0;
      n = 0;
      while (ready !== 1'b1 && n < 300) begin
         @(posedge mclk);
         n++;
      end
      chk("wake edge", 1, ready);
   endtask
   // config pin, break, checksum and sniffer under one flag word
   task automatic mode_test(input logic [15:0] f);
      boot(f);
      led_seen = 0;
      wb(1'b1, 8'h10, 32'h0, q);
      txq.delete();
      i_host.send('{8'h5A});
      data_req_pin_n <= 1'b0;
      repeat (40) @(posedge mclk);
      data_req_pin_n <= 1'b1;
      chk("dreq", !f[1], txq.size());
      config_pin_n <= 1'b0;
      repeat (5) @(posedge mclk);
      config_pin_n <= 1'b1;
      repeat (20) @(posedge mclk);
      chk("cfg pin", !f[0], op_mode);
      uart_rx_pin <= 1'b0;
      repeat (30) @(posedge mclk);
      uart_rx_pin <= 1'b1;
      cs_ok_in <= 1'b0;
      repeat (10) @(posedge mclk);
      chk("break", !f[0] ^ !f[2], op_mode);
      chk("csum", f[5], cs_accept);
      rx_test(8'h55, f[7]);
      chk("leds", f[9], led_seen != 0);
      sleep_pin <= 1'b1;
      transceiver_off_pin <= 1'b1;
      repeat (20) @(posedge mclk);
      chk("pwr ready", f[3], ready);
      chk("pwr rts", !f[3], rts_pin_n);
      sleep_pin <= 1'b0;
      transceiver_off_pin <= 1'b0;
      @(posedge mclk);
   endtask
   // main sequence
   initial begin
      mclk = 0;
      rst = 1;
      {wb_we_i, wb_cyc_i, wb_stb_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
      {reset_pin_n, config_pin_n, data_req_pin_n, uart_rx_pin} = 4'hF;
      {sleep_pin, transceiver_off_pin, pkt_end, txf_ready} = 4'h0;
      {rxf_valid, rxf_last, rxf_data} = '0;
      cs_ok_in = 1;
      {bad_count, n_checks, cycles, starts, led_seen} = '0;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      wb(1'b0, 8'h00, 32'h0, q);
      chk("flags rst", 0, q);
      wb(1'b0, 8'h3C, 32'h0, q);
      chk("unmapped", 0, q);
      boot(16'h0000);
      tx_test();
      rx_test(8'h00, 1'b1);
      rx_test(8'hFF, 1'b1);
      chk("leds off", 0, led_seen);
      wor_test();
      foreach (fl[i]) mode_test(fl[i]);
      complete_run();
   end
endmodule
`default_nettype wire

// [verilog/rmhc_core.sv]
// radio module control: boot/reset handshake on rts, power states with
// timed wake-receive, flag word, and the uart <-> transceiver packet path.
// assumes a classic wishbone master on mclk and asynchronous pins.
//
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - timed wake: receive-ready after countdown times interval divider over 4096 s.
// - receive window lasts the configured milliseconds, then lowest-power sleep.
// - flag bit 0 makes the config pin unable to toggle operating mode.
// - flag bit 1 ignores the transmit request pin, used in transparent mode.
// - flag bit 2 suppresses uart break detection and its mode toggle.
// - flag bit 3 ignores the low-power and transceiver-off pin levels.
// - flag bit 5 accepts any checksum byte in command mode.
// - flag bit 7 skips address filtering, every packet goes to uart.
// - flag bit 8 honours cts; host must drive cts or uart output blocks.
// - flag bit 9 enables the receive and transmit activity outputs.
// - flag bits 0 and 2 together leave only software writes able to change the operating mode.
// - rts high during boot, then low; low for 5 ms means ready.
// - rts rises about 100 us after release, calibration 2 to 1000 ms.
// - sleep entry and exit shown on rts; host waits after waking.
// - uart data buffered until a trigger, then rts high and moved out.
// - radio start on first byte in transceiver fifo, rest fed in chunks.
// - received packet read whole, address checked, then sent to uart.
// - timed wake intervals of divider over 4096 s count the countdown.
// - falling edge on low-power or transceiver-off pin leaves sleep.
module rmhc_core
   import rmhc_pkg::*;
#(
   parameter int CYC_INIT_P = CYC_INIT,
   parameter int CYC_MS_P = CYC_MS,
   parameter int CYC_WOR_P = CYC_WOR,
   parameter int CYC_BRK_P = CYC_BRK,
   parameter int CAL_MS_P = T_CAL_MS
)(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic reset_pin_n,
   input wire logic config_pin_n,
   input wire logic data_req_pin_n,
   input wire logic sleep_pin,
   input wire logic transceiver_off_pin,
   input wire logic uart_rx_pin,
   input wire logic cts_pin_n,
   output logic rts_pin_n,
   output logic rx_led,
   output logic tx_led,
   output logic receive_indicate_pin_n,
   input wire logic hin_valid,
   input wire logic [7:0] hin_data,
   output logic hin_ready,
   input wire logic pkt_end,
   output logic hout_valid,
   output logic [7:0] hout_data,
   input wire logic hout_ready,
   output logic txf_valid,
   output logic [7:0] txf_data,
   input wire logic txf_ready,
   output logic radio_tx_start,
   input wire logic rxf_valid,
   input wire logic [7:0] rxf_data,
   input wire logic rxf_last,
   input wire logic cs_ok_in,
   output logic cs_accept,
   output logic op_mode,
   output logic ready
);
   rmhc_state_type st_reg, st_next;
   logic [6:0] s1_reg, s2_reg, s3_reg, stb_reg, stp_reg;
   logic [15:0] flags_reg, presc_reg, count_reg, win_reg, act_flags;
   logic [7:0] addr_reg, dest;
   logic [31:0] cyc_reg, unit_reg, cyc_lim, unit_tgt, brk_reg;
   logic wrap, done, idle, sleep_eff, trx_eff, wake_fall, uart_on, rx_on;
   logic mode_tgl, brk_evt, wb_hit, wb_wr, rts_next, cts_ok, pass;
   logic tx_trig, tx_move, rx_out, rx_take;
   logic [6:0] tx_cnt, tx_rd, rx_cnt, rx_rd;
   logic [7:0] tx_mem [BUF_DEPTH];
   logic [7:0] rx_mem [BUF_DEPTH];

   // merge the low half-word of a bus write under its byte enables
   function automatic logic [15:0] wmerge(input logic [15:0] old,
         input logic [31:0] d, input logic [3:0] sel);
      wmerge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
   endfunction

   // three-stage synchronisers; a lane counts once stages two and three agree
   always_ff @(posedge mclk) begin
      if (rst) begin
         s1_reg <= RST_PINS;
         s2_reg <= RST_PINS;
         s3_reg <= RST_PINS;
         stb_reg <= RST_PINS;
         stp_reg <= RST_PINS;
      end else begin
         s1_reg <= {cts_pin_n, uart_rx_pin, transceiver_off_pin, sleep_pin,
                    data_req_pin_n, config_pin_n, reset_pin_n};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         stb_reg <= (s2_reg & s3_reg) | (stb_reg & (s2_reg ^ s3_reg));
         stp_reg <= stb_reg;
      end
   end

   // power pins; ignoring them keeps the block awake
   assign sleep_eff = stb_reg[P_SLP] & ~act_flags[F_PWR];
   assign trx_eff = stb_reg[P_TRX] & ~act_flags[F_PWR];
   assign wake_fall = (stp_reg[P_SLP] & ~stb_reg[P_SLP]) |
                      (stp_reg[P_TRX] & ~stb_reg[P_TRX]);
   assign idle = ~tx_move & (tx_cnt == 7'h00) & ~rx_out;
   assign uart_on = (st_reg == ST_ACTIVE) | (st_reg == ST_WOR_RX);
   assign rx_on = uart_on & ~trx_eff;

   // per-state cycle limit and unit target of the shared timer
   always_comb begin
      cyc_lim = 32'(CYC_MS_P);
      unit_tgt = 32'h00000000;
      unique case (st_reg)
         ST_INIT: begin
            cyc_lim = 32'(CYC_INIT_P);
            unit_tgt = 32'h00000001;
         end
         ST_BOOT: unit_tgt = 32'(CAL_MS_P);
         ST_READY: unit_tgt = 32'(T_READY_MS);
         ST_WOR_WAIT: begin
            cyc_lim = 32'(CYC_WOR_P);
            unit_tgt = {16'h0000, presc_reg} * {16'h0000, count_reg};
         end
         ST_WOR_RX: unit_tgt = {16'h0000, win_reg};
         ST_HOLD, ST_ACTIVE, ST_SLEEP: unit_tgt = 32'h00000000;
      endcase
   end
   assign wrap = cyc_reg >= cyc_lim - 32'h00000001;
   assign done = wrap & (unit_reg + 32'h00000001 >= unit_tgt);

   // power and boot sequence; a low reset pin overrides every state
   always_comb begin
      st_next = st_reg;
      if (!stb_reg[P_RST]) begin
         st_next = ST_HOLD;
      end else begin
         unique case (st_reg)
            ST_HOLD: st_next = ST_INIT;
            ST_INIT: if (done) st_next = ST_BOOT;
            ST_BOOT: if (done) st_next = ST_READY;
            ST_READY: if (done) st_next = ST_ACTIVE;
            ST_ACTIVE: begin
               if (idle && sleep_eff) begin
                  st_next = trx_eff ? ST_SLEEP : ST_WOR_WAIT;
               end
            end
            ST_SLEEP: if (wake_fall) st_next = ST_READY;
            ST_WOR_WAIT: begin
               if (wake_fall) st_next = ST_READY;
               else if (done) st_next = ST_WOR_RX;
            end
            ST_WOR_RX: begin
               if (wake_fall) st_next = ST_READY;
               else if (done) st_next = ST_SLEEP;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) st_reg <= ST_HOLD;
      else st_reg <= st_next;
   end

   // shared timer restarts on every state change
   always_ff @(posedge mclk) begin
      if (rst || st_next != st_reg) begin
         cyc_reg <= 32'h00000000;
         unit_reg <= 32'h00000000;
      end else if (wrap) begin
         cyc_reg <= 32'h00000000;
         unit_reg <= unit_reg + 32'h00000001;
      end else begin
         cyc_reg <= cyc_reg + 32'h00000001;
      end
   end

   // rts: high while booting, asleep, or while uart input must stop
   always_comb begin
      unique case (st_reg)
         ST_HOLD, ST_INIT, ST_READY: rts_next = 1'b0;
         ST_BOOT, ST_SLEEP, ST_WOR_WAIT: rts_next = 1'b1;
         ST_ACTIVE, ST_WOR_RX: rts_next = tx_move | tx_trig |
                                          (7'(BUF_DEPTH) == tx_cnt);
      endcase
   end

   // active flags taken as the boot starts, reserved bits dropped
   always_ff @(posedge mclk) begin
      if (rst) begin
         act_flags <= 16'h0000;
         rts_pin_n <= 1'b0;
         ready <= 1'b0;
         cs_accept <= 1'b0;
      end else begin
         if (st_reg == ST_INIT && done) act_flags <= flags_reg & FLAGS_MASK;
         rts_pin_n <= rts_next;
         ready <= st_reg == ST_ACTIVE;
         cs_accept <= cs_ok_in | act_flags[F_CSUM];
      end
   end

   // break: rx line held low for the break time gives one event
   always_ff @(posedge mclk) begin
      if (rst || stb_reg[P_URX]) brk_reg <= 32'h00000000;
      else if (brk_reg != 32'(CYC_BRK_P)) brk_reg <= brk_reg + 32'h00000001;
   end
   assign brk_evt = brk_reg == 32'(CYC_BRK_P - 1);
   assign mode_tgl = (stp_reg[P_CFG] & ~stb_reg[P_CFG] & ~act_flags[F_CFGPIN])
                     | (brk_evt & ~act_flags[F_BRK]);

   // operating mode: software sets it, the config pin and break toggle it
   always_ff @(posedge mclk) begin
      if (rst) op_mode <= RST_MODE;
      else if (wb_wr && wb_adr_i == OFS_CTRL && wb_sel_i[0]) op_mode <= wb_dat_i[0];
      else if (mode_tgl) op_mode <= ~op_mode;
   end

   // transmit trigger; the request pin counts only in transparent mode
   assign tx_trig = ~tx_move & (tx_cnt != 7'h00) & (pkt_end |
                    (tx_cnt == 7'(BUF_DEPTH)) | (stp_reg[P_DREQ] &
                    ~stb_reg[P_DREQ] & ~op_mode & ~act_flags[F_DREQ]));
   assign hin_ready = uart_on & ~tx_move & (tx_cnt != 7'(BUF_DEPTH));
   assign txf_valid = tx_move;
   assign txf_data = tx_mem[tx_rd[5:0]];

   // buffer storage needs no reset
   always_ff @(posedge mclk) begin
      if (hin_valid && hin_ready) tx_mem[tx_cnt[5:0]] <= hin_data;
      if (rx_take) rx_mem[rx_cnt[5:0]] <= rxf_data;
   end

   // transmit path: fill, then stream to the transceiver fifo with stalls
   always_ff @(posedge mclk) begin
      if (rst || st_reg == ST_HOLD) begin
         tx_cnt <= 7'h00;
         tx_rd <= 7'h00;
         tx_move <= 1'b0;
         radio_tx_start <= 1'b0;
      end else begin
         radio_tx_start <= 1'b0;
         if (hin_valid && hin_ready) tx_cnt <= tx_cnt + 7'h01;
         if (tx_trig) begin
            tx_move <= 1'b1;
            tx_rd <= 7'h00;
         end
         if (tx_move && txf_ready) begin
            tx_rd <= tx_rd + 7'h01;
            radio_tx_start <= tx_rd == 7'h00;
            if (tx_rd == tx_cnt - 7'h01) begin
               tx_move <= 1'b0;
               tx_cnt <= 7'h00;
            end
         end
      end
   end

   // receive: whole packet stored, destination byte checked at its end
   assign rx_take = rxf_valid & rx_on & ~rx_out & (rx_cnt != 7'(BUF_DEPTH));
   assign dest = (rx_cnt == 7'h00) ? rxf_data : rx_mem[0];
   assign pass = act_flags[F_SNIFF] | (dest == addr_reg) |
                 (dest == BCAST_ADDR);
   assign cts_ok = ~act_flags[F_CTS] | ~stb_reg[P_CTS];
   assign hout_valid = rx_out & cts_ok;
   assign hout_data = rx_mem[rx_rd[5:0]];

   always_ff @(posedge mclk) begin
      if (rst || st_reg == ST_HOLD) begin
         rx_cnt <= 7'h00;
         rx_rd <= 7'h00;
         rx_out <= 1'b0;
      end else if (rx_take) begin
         rx_cnt <= rx_cnt + 7'h01;
         if (rxf_last) begin
            rx_rd <= 7'h00;
            if (pass) rx_out <= 1'b1;
            else rx_cnt <= 7'h00;
         end
      end else if (rxf_valid && rxf_last && !rx_out) begin
         rx_cnt <= 7'h00; // truncated packet is dropped
      end else if (hout_valid && hout_ready) begin
         rx_rd <= rx_rd + 7'h01;
         if (rx_rd == rx_cnt - 7'h01) begin
            rx_out <= 1'b0;
            rx_cnt <= 7'h00;
         end
      end
   end

   // activity outputs follow the flag
   assign rx_led = act_flags[F_LED] & rx_out;
   assign tx_led = act_flags[F_LED] & tx_move;
   assign receive_indicate_pin_n = ~rx_out;

   // wishbone slave: one wait state, unmapped reads zero, writes dropped
   assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wb_wr = wb_hit & wb_we_i;
   always_ff @(posedge mclk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_hit;
         unique case (wb_adr_i)
            OFS_FLAGS: wb_dat_o <= {16'h0000, flags_reg};
            OFS_PRESC: wb_dat_o <= {16'h0000, presc_reg};
            OFS_COUNT: wb_dat_o <= {16'h0000, count_reg};
            OFS_WIN: wb_dat_o <= {16'h0000, win_reg};
            OFS_CTRL: wb_dat_o <= {16'h0000, addr_reg, 7'h00, op_mode};
            OFS_STAT: wb_dat_o <= {act_flags, 8'h00, tx_move, ready,
                                   op_mode, rts_pin_n, 1'b0, st_reg};
            default: wb_dat_o <= 32'h00000000;
         endcase
      end
   end

   // configuration registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         flags_reg <= RST_FLAGS;
         presc_reg <= RST_PRESC;
         count_reg <= RST_COUNT;
         win_reg <= RST_WIN;
         addr_reg <= RST_ADDR;
      end else if (wb_wr) begin
         unique case (wb_adr_i)
            OFS_FLAGS: flags_reg <= wmerge(flags_reg, wb_dat_i, wb_sel_i);
            OFS_PRESC: presc_reg <= wmerge(presc_reg, wb_dat_i, wb_sel_i);
            OFS_COUNT: count_reg <= wmerge(count_reg, wb_dat_i, wb_sel_i);
            OFS_WIN: win_reg <= wmerge(win_reg, wb_dat_i, wb_sel_i);
            OFS_CTRL: if (wb_sel_i[1]) addr_reg <= wb_dat_i[15:8];
            default: ;
         endcase
      end
   end

   a_trig_rts: assert property (@(posedge mclk) disable iff (rst)
      tx_trig && st_reg == ST_ACTIVE |=> rts_pin_n && tx_move)
      else $error("rts not raised on packet trigger");
   a_led_gate: assert property (@(posedge mclk) disable iff (rst)
      !act_flags[F_LED] |-> !rx_led && !tx_led)
      else $error("activity output while disabled");
   a_cts_hold: assert property (@(posedge mclk) disable iff (rst)
      act_flags[F_CTS] && stb_reg[P_CTS] |-> !hout_valid)
      else $error("uart output despite cts");
   a_mode_lock: assert property (@(posedge mclk) disable iff (rst)
      act_flags[F_CFGPIN] && act_flags[F_BRK] && !wb_wr
      |=> $stable(op_mode))
      else $error("operating mode changed while locked");
   a_boot_rts: assert property (@(posedge mclk) disable iff (rst)
      st_reg == ST_INIT && st_next == ST_BOOT
      |-> cyc_reg == 32'(CYC_INIT_P - 1) ##2 rts_pin_n)
      else $error("rts not raised after boot delay");
   a_sniff_pass: assert property (@(posedge mclk) disable iff (rst)
      rx_take && rxf_last && act_flags[F_SNIFF] |=> rx_out)
      else $error("packet dropped in sniffer mode");
   a_csum_any: assert property (@(posedge mclk) disable iff (rst)
      act_flags[F_CSUM] |=> cs_accept)
      else $error("checksum refused with debug flag");
   a_ack_pulse: assert property (@(posedge mclk) disable iff (rst)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus acknowledge not a single cycle");
   a_sleep_ign: assert property (@(posedge mclk) disable iff (rst)
      act_flags[F_PWR] && st_reg == ST_ACTIVE |=> st_reg != ST_SLEEP
      && st_reg != ST_WOR_WAIT)
      else $error("sleep entered with power pins ignored");
endmodule
`default_nettype wire
